// ==== hdl/diag_status_flag_registers.sv ====
`timescale 1ns/10ps
module diag_status_flag_registers
  import diag_flag_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // register read port from the serial front end
  input  wire logic        rd_stb,
  input  wire logic [7:0]  rd_addr,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  // self-test and hardware check results, one-cycle pulses
  input  wire logic        vector_magnitude_fault_evt,
  input  wire logic [2:0]  axis_accel_fault_evt,
  input  wire logic        temp_fault_evt,
  input  wire logic        supply_fault_evt,
  input  wire logic        startup_check_fault_evt,
  input  wire logic        output_select_invalid,
  input  wire logic        flash_fault_evt,
  input  wire logic        backup_fault_evt,
  // serial transmit pacing
  input  wire logic        sample_ready,
  input  wire logic        tx_busy,
  // measurement events
  input  wire logic        temp_data_evt,
  input  wire logic [2:0]  axis_data_evt,
  input  wire logic [2:0]  resonance_evt,
  input  wire logic [2:0]  threshold_evt,
  input  wire logic        sample_output_done,
  input  wire logic        burst_or_auto,
  input  wire logic        normal_mode,
  // sensor value path
  input  wire logic [15:0] sensor_value,
  output logic      [15:0] sensor_value_out,
  // state shown to the rest of the device
  output logic             any_failure_summary,
  output logic             range_hold
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        vector_magnitude_fault;
    logic [2:0]  axis_accel_fault;
    logic        temp_fault;
    logic        supply_fault;
    logic [2:0]  hardware_check_fault;
    logic        serial_overflow;
    logic        flash_fault;
    logic        backup_fault;
    logic        any_failure_summary;
    logic        temp_fresh;
    logic [2:0]  axis_fresh;
    logic        range_hold;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic [15:0] value_out;
  } regs_state_t;

  regs_state_t state_reg;
  regs_state_t state_next;

  logic [2:0]  resonance_flag;
  logic [2:0]  threshold_flag;
  logic [2:0]  event_clear;
  logic [15:0] diag_word;
  logic [15:0] flag_word;
  logic        diag_read;
  logic        flag_read;
  logic        temp_read;
  logic [2:0]  axis_read;
  logic        overflow_evt;
  logic        any_fault_evt;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  assign diag_read   = rd_stb && (rd_addr == DIAG_STATUS_ADDR);
  assign flag_read   = rd_stb && (rd_addr == EVENT_FLAGS_ADDR);
  assign temp_read   = rd_stb && (rd_addr == TEMP_WORD_ADDR || rd_addr == TEMP_BYTE_ADDR);
  assign axis_read   = {rd_stb && (rd_addr == X_VELOCITY_ADDR),
                        rd_stb && (rd_addr == Y_VELOCITY_ADDR),
                        rd_stb && (rd_addr == Z_VELOCITY_ADDR)};

  // a new sample while the transmitter is still busy is lost
  assign overflow_evt = sample_ready & tx_busy;

  // register read clear and per-sample clear share one strobe
  assign event_clear = {3{flag_read | (burst_or_auto & sample_output_done)}};

  // ----------------------------------------------------------------
  // resonance and alarm flags
  // ----------------------------------------------------------------
  axis_flag_cell resonance_cell (
    .mclk     (mclk),
    .rst      (rst),
    .set_in   (resonance_evt),
    .clr_in   (event_clear),
    .flag_out (resonance_flag)
  );

  axis_flag_cell threshold_cell (
    .mclk     (mclk),
    .rst      (rst),
    .set_in   (threshold_evt),
    .clr_in   (event_clear),
    .flag_out (threshold_flag)
  );

  // any result event feeds the summary bit
  assign any_fault_evt = vector_magnitude_fault_evt | (|axis_accel_fault_evt) | temp_fault_evt
                       | supply_fault_evt | startup_check_fault_evt | output_select_invalid
                       | overflow_evt | flash_fault_evt | backup_fault_evt;

  // ----------------------------------------------------------------
  // register images
  // ----------------------------------------------------------------
  always_comb begin
    diag_word = DIAG_RESET;
    diag_word[VEC_FAULT_BIT] = state_reg.vector_magnitude_fault;
    diag_word[X_ACC_FAULT_BIT:Z_ACC_FAULT_BIT] = state_reg.axis_accel_fault;
    diag_word[TEMP_FAULT_BIT] = state_reg.temp_fault;
    diag_word[SUPPLY_FAULT_BIT] = state_reg.supply_fault;
    diag_word[HW_FAULT_LSB+2:HW_FAULT_LSB] = state_reg.hardware_check_fault;
    diag_word[OVERFLOW_BIT] = state_reg.serial_overflow;
    diag_word[FLASH_FAULT_BIT] = state_reg.flash_fault;
    diag_word[COMBINED_FAULT_BIT] = state_reg.vector_magnitude_fault
                                  | (|state_reg.axis_accel_fault);
    diag_word[BACKUP_FAULT_BIT] = state_reg.backup_fault;
  end

  always_comb begin
    flag_word = DIAG_RESET;
    flag_word[TEMP_FRESH_BIT] = state_reg.temp_fresh;
    flag_word[AXIS_FRESH_LSB+2:AXIS_FRESH_LSB] = state_reg.axis_fresh;
    flag_word[RESONANCE_LSB+2:RESONANCE_LSB] = resonance_flag;
    flag_word[THRESHOLD_LSB+2:THRESHOLD_LSB] = threshold_flag;
    flag_word[SUMMARY_BIT] = state_reg.any_failure_summary;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // diagnostic results: set wins over the read clear
    state_next.vector_magnitude_fault = vector_magnitude_fault_evt
                                      | (state_reg.vector_magnitude_fault & ~diag_read);
    state_next.axis_accel_fault = axis_accel_fault_evt
                                | (state_reg.axis_accel_fault & ~{3{diag_read}});
    state_next.temp_fault = temp_fault_evt | (state_reg.temp_fault & ~diag_read);
    state_next.supply_fault = supply_fault_evt | (state_reg.supply_fault & ~diag_read);
    state_next.flash_fault = flash_fault_evt | (state_reg.flash_fault & ~diag_read);
    state_next.backup_fault = backup_fault_evt | (state_reg.backup_fault & ~diag_read);
    state_next.serial_overflow = overflow_evt | (state_reg.serial_overflow & ~diag_read);
    // startup failure and bad output selection get separate codes
    state_next.hardware_check_fault = diag_read ? HW_FAULT_NONE : state_reg.hardware_check_fault;
    if (startup_check_fault_evt) begin
      state_next.hardware_check_fault[0] = 1'b1;
    end
    if (output_select_invalid) begin
      state_next.hardware_check_fault[1] = 1'b1;
    end
    state_next.any_failure_summary = any_fault_evt
                                   | (state_reg.any_failure_summary & ~diag_read);
    // fresh-data markers
    state_next.temp_fresh = temp_data_evt | (state_reg.temp_fresh & ~temp_read);
    state_next.axis_fresh = axis_data_evt | (state_reg.axis_fresh & ~axis_read);
    // range clamp stays until the flag register is read
    if (normal_mode && (|resonance_evt)) begin
      state_next.range_hold = 1'b1;
    end else if (flag_read) begin
      state_next.range_hold = 1'b0;
    end
    state_next.value_out = state_next.range_hold ? RANGE_UPPER_LIMIT : sensor_value;
    // read data, registered one cycle after the strobe
    state_next.rd_valid = rd_stb;
    state_next.rd_data  = DIAG_RESET;
    if (diag_read) begin
      state_next.rd_data = diag_word;
    end else if (flag_read) begin
      state_next.rd_data = flag_word;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data             = state_reg.rd_data;
  assign rd_valid            = state_reg.rd_valid;
  assign sensor_value_out    = state_reg.value_out;
  assign any_failure_summary = state_reg.any_failure_summary;
  assign range_hold          = state_reg.range_hold;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_DIAG_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    diag_read && !any_fault_evt |=> !any_failure_summary && diag_word == DIAG_RESET)
    else $error("diag read did not clear results");

  AST_VEC_SET: assert property (@(posedge mclk) disable iff (rst)
    vector_magnitude_fault_evt |=> state_reg.vector_magnitude_fault)
    else $error("vector fault not set");

  AST_AXIS_SET: assert property (@(posedge mclk) disable iff (rst)
    (|axis_accel_fault_evt) |=>
      (state_reg.axis_accel_fault & $past(axis_accel_fault_evt)) == $past(axis_accel_fault_evt))
    else $error("axis fault not held");

  AST_HW_FIELD: assert property (@(posedge mclk) disable iff (rst)
    startup_check_fault_evt |=> state_reg.hardware_check_fault != HW_FAULT_NONE)
    else $error("hardware field stayed zero");

  AST_OVERFLOW: assert property (@(posedge mclk) disable iff (rst)
    sample_ready && tx_busy |=> state_reg.serial_overflow && any_failure_summary)
    else $error("overflow not flagged");

  AST_COMBINED: assert property (@(posedge mclk) disable iff (rst)
    rd_valid && $past(diag_read) |-> rd_data[COMBINED_FAULT_BIT] == (|rd_data[VEC_FAULT_BIT:Z_ACC_FAULT_BIT]))
    else $error("combined bit mismatch");

  AST_FLAG_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    flag_read && !(|resonance_evt) && !(|threshold_evt) |=> resonance_flag == 3'h0 && threshold_flag == 3'h0)
    else $error("flag read did not clear");

  AST_SAMPLE_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    burst_or_auto && sample_output_done && !(|resonance_evt) && !(|threshold_evt)
      |=> resonance_flag == 3'h0 && threshold_flag == 3'h0)
    else $error("sample output did not clear");

  AST_CLAMP: assert property (@(posedge mclk) disable iff (rst)
    normal_mode && resonance_evt[0] ##1 !flag_read |=> sensor_value_out == RANGE_UPPER_LIMIT)
    else $error("range clamp missing");

  AST_TEMP_FRESH: assert property (@(posedge mclk) disable iff (rst)
    temp_data_evt |=> state_reg.temp_fresh)
    else $error("temperature marker not set");

  AST_SET_WINS: assert property (@(posedge mclk) disable iff (rst)
    flag_read |=> ((threshold_flag & $past(threshold_evt)) == $past(threshold_evt))
              && ((resonance_flag & $past(resonance_evt)) == $past(resonance_evt)))
    else $error("set lost to clear");

  COV_DIAG_READ: cover property (@(posedge mclk) disable iff (rst)
    vector_magnitude_fault_evt ##[1:5] diag_read);
  COV_CLAMP_RELEASE: cover property (@(posedge mclk) disable iff (rst)
    range_hold ##[1:5] flag_read ##1 !range_hold);
  COV_SAMPLE_CLEAR: cover property (@(posedge mclk) disable iff (rst)
    threshold_evt[0] ##[1:5] (burst_or_auto && sample_output_done));

endmodule

// ==== hdl/diag_flag_pkg.sv ====
package diag_flag_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  DIAG_STATUS_ADDR   = 8'h04;
  localparam logic [7:0]  EVENT_FLAGS_ADDR   = 8'h06;
  localparam logic [7:0]  TEMP_WORD_ADDR     = 8'h10;
  localparam logic [7:0]  TEMP_BYTE_ADDR     = 8'h2E;
  localparam logic [7:0]  X_VELOCITY_ADDR    = 8'h30;
  localparam logic [7:0]  Y_VELOCITY_ADDR    = 8'h34;
  localparam logic [7:0]  Z_VELOCITY_ADDR    = 8'h38;

  // ----------------------------------------------------------------
  // diagnostic status field positions
  // ----------------------------------------------------------------
  localparam int          VEC_FAULT_BIT      = 15;
  localparam int          X_ACC_FAULT_BIT    = 14;
  localparam int          Z_ACC_FAULT_BIT    = 12;
  localparam int          TEMP_FAULT_BIT     = 9;
  localparam int          SUPPLY_FAULT_BIT   = 8;
  localparam int          HW_FAULT_LSB       = 5;
  localparam int          OVERFLOW_BIT       = 3;
  localparam int          FLASH_FAULT_BIT    = 2;
  localparam int          COMBINED_FAULT_BIT = 1;
  localparam int          BACKUP_FAULT_BIT   = 0;

  // ----------------------------------------------------------------
  // flag register field positions
  // ----------------------------------------------------------------
  localparam int          TEMP_FRESH_BIT     = 15;
  localparam int          AXIS_FRESH_LSB     = 9;
  localparam int          RESONANCE_LSB      = 5;
  localparam int          THRESHOLD_LSB      = 2;
  localparam int          SUMMARY_BIT        = 0;

  // ----------------------------------------------------------------
  // reset values and range clamp limit
  // ----------------------------------------------------------------
  localparam logic [15:0] DIAG_RESET         = 16'h0000;
  localparam logic [2:0]  FLAG3_RESET        = 3'h0;
  localparam logic [2:0]  HW_FAULT_NONE      = 3'h0;
  localparam logic [15:0] RANGE_UPPER_LIMIT  = 16'h7FFF;

endpackage

// ==== hdl/axis_flag_cell.sv ====
`timescale 1ns/10ps
// three sticky per-axis flags; a set in the clear cycle wins
module axis_flag_cell
  import diag_flag_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // events
  input  wire logic [2:0] set_in,
  input  wire logic [2:0] clr_in,
  // state
  output logic      [2:0] flag_out
);

  typedef struct packed {
    logic [2:0] flag;
  } cell_state_t;

  cell_state_t state_reg;
  cell_state_t state_next;

  // per-axis sticky logic
  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < 3; i++) begin
      state_next.flag[i] = set_in[i] | (state_reg.flag[i] & ~clr_in[i]);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg.flag <= FLAG3_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flag_out = state_reg.flag;

endmodule

// ==== verif/host_reader.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// host side of the register read port
// ----------------------------------------------------------------
module host_reader (
  // clock
  input  wire logic        mclk,
  // read port toward the register bank
  output logic             rd_stb,
  output logic      [7:0]  rd_addr,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid
);
  // idle state: no strobe, address parked on a value nobody decodes
  initial begin
    rd_stb  = 1'b0;
    rd_addr = 8'hFF;
  end

  // one read: strobe taken at one edge, answer stands the following cycle
  task automatic do_read(input logic [7:0] addr, output logic [15:0] data, output logic ok);
    @(negedge mclk);
    rd_stb  = 1'b1;
    rd_addr = addr;
    @(negedge mclk);
    data    = rd_data;
    ok      = rd_valid;
    rd_stb  = 1'b0;
    rd_addr = ~addr; // released address shows garbage, not the last value
  endtask
endmodule

// ==== verif/diag_status_flag_registers_tb.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// register bank testbench
// ----------------------------------------------------------------
module diag_status_flag_registers_tb;
  import diag_flag_pkg::*;

  logic        mclk;
  logic        rst;
  logic        rd_stb;
  logic [7:0]  rd_addr;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic [10:0] ev;
  logic [10:0] mv;
  logic        tx_busy;
  logic        burst_or_auto;
  logic        normal_mode;
  logic [15:0] sensor_value;
  logic [15:0] sensor_value_out;
  logic        any_failure_summary;
  logic        range_hold;
  int          n_errors;
  int          compares;
  // expected diag image for each single fault event, combined bit included
  logic [15:0] diag_exp [0:10] = '{16'h8002, 16'h1002, 16'h2002, 16'h4002, 16'h0200, 16'h0100,
                                   16'h0020, 16'h0040, 16'h0004, 16'h0001, 16'h0008};

  // clock at 100 MHz
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  diag_status_flag_registers dut (
    .mclk(mclk), .rst(rst), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .vector_magnitude_fault_evt(ev[0]), .axis_accel_fault_evt(ev[3:1]), .temp_fault_evt(ev[4]),
    .supply_fault_evt(ev[5]), .startup_check_fault_evt(ev[6]), .output_select_invalid(ev[7]),
    .flash_fault_evt(ev[8]), .backup_fault_evt(ev[9]), .sample_ready(ev[10]), .tx_busy(tx_busy),
    .temp_data_evt(mv[0]), .axis_data_evt(mv[3:1]), .resonance_evt(mv[6:4]), .threshold_evt(mv[9:7]),
    .sample_output_done(mv[10]), .burst_or_auto(burst_or_auto), .normal_mode(normal_mode),
    .sensor_value(sensor_value), .sensor_value_out(sensor_value_out),
    .any_failure_summary(any_failure_summary), .range_hold(range_hold));

  host_reader u_host (
    .mclk(mclk), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // rd_valid must accompany every answer, unmapped ones too
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    u_host.do_read(a, d, v);
    chk({15'h0000, v}, 16'h0001);
    chk(d, exp);
  endtask

  // one-cycle event pulses, launched off the falling edge
  task automatic pulse(input logic [10:0] e, input logic [10:0] m);
    @(negedge mclk);
    ev = e;
    mv = m;
    @(negedge mclk);
    ev = '0;
    mv = '0;
  endtask

  task automatic print_verdict();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n_errors = 0;
    compares = 0;
    rst = 1'b1;
    ev = '0;
    mv = '0;
    tx_busy = 1'b0;
    burst_or_auto = 1'b0;
    normal_mode = 1'b1;
    sensor_value = 16'h1234;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    rd(DIAG_STATUS_ADDR, DIAG_RESET);
    rd(EVENT_FLAGS_ADDR, 16'h0000);
    // each fault alone, then the clearing read
    for (int i = 0; i < 11; i++) begin
      tx_busy = (i == 10);
      pulse(11'h001 << i, '0);
      tx_busy = 1'b0;
      chk({15'h0000, any_failure_summary}, 16'h0001);
      rd(EVENT_FLAGS_ADDR, 16'h0001);
      rd(DIAG_STATUS_ADDR, diag_exp[i]);
      rd(DIAG_STATUS_ADDR, 16'h0000);
      rd(EVENT_FLAGS_ADDR, 16'h0000);
    end
    // a sample with an idle transmitter is no overflow
    pulse(11'h400, '0);
    rd(DIAG_STATUS_ADDR, 16'h0000);
    rd(8'h08, 16'h0000);
    rd(8'h05, 16'h0000);
    // resonance clamps the value until the flag read
    pulse('0, 11'h3F0);
    @(negedge mclk);
    chk({15'h0000, range_hold}, 16'h0001);
    chk(sensor_value_out, RANGE_UPPER_LIMIT);
    rd(EVENT_FLAGS_ADDR, 16'h00FC);
    @(negedge mclk);
    chk({15'h0000, range_hold}, 16'h0000);
    chk(sensor_value_out, 16'h1234);
    rd(EVENT_FLAGS_ADDR, 16'h0000);
    // sample output clears flags in burst or auto sampling
    normal_mode = 1'b0;
    burst_or_auto = 1'b1;
    pulse('0, 11'h210);
    chk({15'h0000, range_hold}, 16'h0000);
    rd(EVENT_FLAGS_ADDR, 16'h0030);
    pulse('0, 11'h210);
    pulse('0, 11'h400);
    rd(EVENT_FLAGS_ADDR, 16'h0000);
    burst_or_auto = 1'b0;
    // fresh-data markers, each cleared by its own register read
    pulse('0, 11'h00F);
    rd(EVENT_FLAGS_ADDR, 16'h8E00);
    rd(TEMP_WORD_ADDR, 16'h0000);
    rd(EVENT_FLAGS_ADDR, 16'h0E00);
    rd(X_VELOCITY_ADDR, 16'h0000);
    rd(EVENT_FLAGS_ADDR, 16'h0600);
    rd(Y_VELOCITY_ADDR, 16'h0000);
    rd(Z_VELOCITY_ADDR, 16'h0000);
    rd(EVENT_FLAGS_ADDR, 16'h0000);
    pulse('0, 11'h001);
    rd(TEMP_BYTE_ADDR, 16'h0000);
    rd(EVENT_FLAGS_ADDR, 16'h0000);
    // set and clearing read in the same cycle: the set survives
    fork
      rd(EVENT_FLAGS_ADDR, 16'h0000);
      pulse('0, 11'h200);
    join
    rd(EVENT_FLAGS_ADDR, 16'h0010);
    fork
      rd(DIAG_STATUS_ADDR, 16'h0000);
      pulse(11'h200, '0);
    join
    rd(EVENT_FLAGS_ADDR, 16'h0001);
    rd(DIAG_STATUS_ADDR, 16'h0001);
    print_verdict();
  end
endmodule
